/* File: verilog/rmb_reset_mode_bias.sv */
// Strap, reset, calibration start and serial register logic of the front end
//
// Summary of operation
// [RL1] Bias register: 7:5, 4:3, 2:0 fields
// [RL2] Bias register is zero after any reset
// [RL3] Converter low-power bit equals bias code 011
// [RL4] Duplex strap low half, high full
// [RL5] Strap pair picks the PD_HIGH serial register default; other defaults are fixed
// [RL6] Select pin held high ignores serial traffic
// [RL7] Reset pin or soft bit restores defaults
// [RL8] Calibration only after hardware reset
// [RL9] Resets never clear transmit filter pipeline
// [RL10] Host holds reset low at least 50 ns
// [RL11] Registers default instantly on reset pin low
// [RL12] Calibration starts on reset pin rising
// [RL13] Host holds reset 10 ms after power
// [RL14] Soft reset bit reads back as zero
`timescale 1ns/1ps
`include "rmb_defs.svh"
module rmb_reset_mode_bias #(
    parameter int unsigned PWR_ON_CYCLES = `RMB_PWR_ON_CYC,
    parameter int unsigned CAL_CYCLES    = `RMB_CAL_CYC
) (
    input  wire logic         CLK_SYS,
    input  wire logic         RST_N,
    input  wire logic         RESET_PIN_N,
    input  wire logic         DUPLEX_STRAP,
    input  wire logic         CONFIG_STRAP,
    input  wire logic         SERIAL_PORT_SELECT_N,
    input  wire logic         SERIAL_CLK,
    input  wire logic         SERIAL_DATA_I,
    output logic              SERIAL_DATA_O,
    output logic              SERIAL_DATA_OE,
    output logic              FULL_DUPLEX,
    output rmb_pkg::rmb_byte_t PD_LOW_SET,
    output rmb_pkg::rmb_byte_t PD_HIGH_SET,
    output rmb_pkg::rmb_byte_t HDX_PWR_CFG,
    output logic [2:0]        CONTINUOUS_GAIN_AMP_BIAS,
    output logic [1:0]        SWITCHED_GAIN_AMP_BIAS,
    output logic [2:0]        CONVERTER_BIAS,
    output logic              SOFT_RST_PULSE,
    output logic              CAL_START,
    output logic              CAL_BUSY
);
    import rmb_pkg::*;

    localparam int unsigned NREG = 6;

    logic      rst_pin_s;
    logic      duplex_s;
    logic      config_s;
    logic      sel_n_s;
    logic      sclk_s;
    logic      sdi_s;
    logic      rst_pin_d_r;
    logic      sclk_d_r;
    logic      hw_rst_n;
    logic      strap_duplex_r;
    logic      strap_config_r;
    rmb_byte_t delta_r [NREG];
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    rmb_byte_t out_r;
    logic      rd_r;
    logic      soft_rst_r;
    logic      wr_fire;
    rmb_addr_t wr_addr;
    rmb_byte_t wr_data;
    logic      sclk_rise;
    logic      sclk_fall;
    logic      early_r;
    logic [31:0] pwr_cnt_r;
    logic [31:0] cal_cnt_r;
    rmb_cal_e  cal_state_r;
    rmb_cal_e  cal_state_nxt;
    rmb_byte_t bias_eff;
    rmb_byte_t conv_lp_val;

    // Map an offset onto a storage index; NREG marks an unmapped offset
    function automatic int unsigned addr_idx(input rmb_addr_t a);
        int unsigned i;
        i = NREG;
        if (a == `RMB_ADDR_CTRL) begin
            i = 0;
        end else if (a == `RMB_ADDR_PD_LOW) begin
            i = 1;
        end else if (a == `RMB_ADDR_PD_HIGH) begin
            i = 2;
        end else if (a == `RMB_ADDR_HDX_PWR) begin
            i = 3;
        end else if (a == `RMB_ADDR_CONV_LP) begin
            i = 4;
        end else if (a == `RMB_ADDR_BIAS) begin
            i = 5;
        end
        return i;
    endfunction

    // Default contents; the strap pair chooses only the PD_HIGH default
    function automatic rmb_byte_t def_val(input int unsigned i,
                                          input logic dup,
                                          input logic cfg);
        rmb_byte_t v;
        v = 8'h00;
        case (i)
            0: v = `RMB_RST_CTRL;
            1: v = `RMB_RST_PD_LOW;
            2: v = (dup && cfg) ? `RMB_RST_PD_HIGH_ALL
                                : `RMB_RST_PD_HIGH; // RL5
            3: v = `RMB_RST_HDX_PWR;
            4: v = `RMB_RST_CONV_LP;
            5: v = `RMB_RST_BIAS; // RL2
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Live value of a register: stored difference over the default
    function automatic rmb_byte_t reg_val(input int unsigned i,
                                          input rmb_byte_t d,
                                          input logic dup,
                                          input logic cfg);
        return d ^ def_val(i, dup, cfg);
    endfunction

    // Every pin is brought into the clock domain; the reset pin is also used raw below
    rmb_sync2 #(.RST_VAL(1'b0)) u_sync_rst (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (RESET_PIN_N),
        .q     (rst_pin_s)
    );
    rmb_sync2 #(.RST_VAL(1'b0)) u_sync_dup (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (DUPLEX_STRAP),
        .q     (duplex_s)
    );
    rmb_sync2 #(.RST_VAL(1'b0)) u_sync_cfg (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (CONFIG_STRAP),
        .q     (config_s)
    );
    rmb_sync2 #(.RST_VAL(1'b1)) u_sync_sel (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (SERIAL_PORT_SELECT_N),
        .q     (sel_n_s)
    );
    rmb_sync2 #(.RST_VAL(1'b0)) u_sync_sck (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (SERIAL_CLK),
        .q     (sclk_s)
    );
    rmb_sync2 #(.RST_VAL(1'b0)) u_sync_sdi (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (SERIAL_DATA_I),
        .q     (sdi_s)
    );

    // The pin clears the register file with no clock at all; a glitch on
    // the pin therefore counts as a reset, which is the intended trade
    assign hw_rst_n = RST_N & RESET_PIN_N; // RL11

    // Edge history for the reset pin and the serial clock
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_pin_d_r <= 1'b0;
            sclk_d_r    <= 1'b0;
        end else begin
            rst_pin_d_r <= rst_pin_s;
            sclk_d_r    <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;

    // Straps are caught while either reset is active, so the defaults
    // follow the pins as they stand at release
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            strap_duplex_r <= 1'b0;
            strap_config_r <= 1'b0;
        end else if (!rst_pin_s || soft_rst_r) begin
            strap_duplex_r <= duplex_s; // RL4
            strap_config_r <= config_s; // RL5
        end
    end

    // Serial shift engine; a deselected port sees no traffic
    always_ff @(posedge CLK_SYS or negedge hw_rst_n) begin
        if (!hw_rst_n) begin
            bit_cnt_r <= 5'h00;
            shift_r   <= 16'h0000;
            rd_r      <= 1'b0;
        end else if (sel_n_s) begin
            bit_cnt_r <= 5'h00; // RL6
            rd_r      <= 1'b0;
        end else if (sclk_rise && bit_cnt_r != `RMB_FRAME_BITS) begin
            shift_r   <= {shift_r[14:0], sdi_s};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h00) begin
                rd_r <= sdi_s;
            end
        end
    end

    assign wr_fire = sclk_rise && !sel_n_s && !rd_r
                     && bit_cnt_r == (`RMB_FRAME_BITS - 5'h01);
    assign wr_addr = shift_r[13:7];
    assign wr_data = {shift_r[6:0], sdi_s};

    // Read data is loaded after the header and moved out on falling edges
    always_ff @(posedge CLK_SYS or negedge hw_rst_n) begin
        if (!hw_rst_n) begin
            out_r <= 8'h00;
        end else if (sel_n_s || !rd_r) begin
            out_r <= 8'h00;
        end else if (sclk_rise && bit_cnt_r == (`RMB_HDR_BITS - 5'h01)) begin
            out_r <= rd_word({shift_r[5:0], sdi_s});
        end else if (sclk_fall && bit_cnt_r > `RMB_HDR_BITS) begin
            out_r <= {out_r[6:0], 1'b0};
        end
    end

    // Read answer; unmapped offsets read as zero
    function automatic rmb_byte_t rd_word(input rmb_addr_t a);
        int unsigned i;
        rmb_byte_t v;
        i = addr_idx(a);
        v = 8'h00;
        if (i < NREG) begin
            v = reg_val(i, delta_r[i], strap_duplex_r, strap_config_r);
        end
        if (i == 0) begin
            v[`RMB_CTRL_SOFT_RST] = 1'b0; // RL14
            v[`RMB_CTRL_EARLY]    = early_r;
        end
        return v;
    endfunction

    // Drive the data pin only through the data phase of a read
    always_comb begin
        SERIAL_DATA_OE = !sel_n_s && rd_r && bit_cnt_r >= `RMB_HDR_BITS;
        SERIAL_DATA_O  = out_r[7];
    end

    // Register storage as difference from the strap default, so an
    // asynchronous clear lands exactly on the default
    always_ff @(posedge CLK_SYS or negedge hw_rst_n) begin
        if (!hw_rst_n) begin
            for (int k = 0; k < NREG; k++) begin
                delta_r[k] <= 8'h00; // RL11
            end
        end else if (soft_rst_r) begin
            for (int k = 0; k < NREG; k++) begin
                delta_r[k] <= 8'h00; // RL7
            end
        end else if (wr_fire && addr_idx(wr_addr) < NREG) begin
            delta_r[addr_idx(wr_addr)] <= wr_data ^
                def_val(addr_idx(wr_addr), strap_duplex_r, strap_config_r);
        end
    end

    // Soft reset request lasts one cycle and clears the bit that the write stored in the control register on the next cycle
    always_ff @(posedge CLK_SYS or negedge hw_rst_n) begin
        if (!hw_rst_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_fire && addr_idx(wr_addr) == 0
                          && wr_data[`RMB_CTRL_SOFT_RST]; // RL7 RL14
        end
    end

    // Host must wait the power-on time before release; an early release
    // is only flagged, since the analog blocks cannot be held off here
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pwr_cnt_r <= 32'h0000_0000;
            early_r   <= 1'b0;
        end else begin
            if (pwr_cnt_r < PWR_ON_CYCLES) begin
                pwr_cnt_r <= pwr_cnt_r + 32'h0000_0001;
            end
            if (rst_pin_s && !rst_pin_d_r && pwr_cnt_r < PWR_ON_CYCLES) begin
                early_r <= 1'b1; // RL13
            end
        end
    end

    // Calibration sequencer: started by the pin's rising edge only
    always_comb begin
        cal_state_nxt = cal_state_r;
        case (cal_state_r)
            RMB_CAL_IDLE: begin
                if (rst_pin_s && !rst_pin_d_r) begin
                    cal_state_nxt = RMB_CAL_RUN; // RL12 RL8
                end
            end
            RMB_CAL_RUN: begin
                if (cal_cnt_r == CAL_CYCLES - 1) begin
                    cal_state_nxt = RMB_CAL_DONE;
                end
            end
            RMB_CAL_DONE: begin
                cal_state_nxt = RMB_CAL_IDLE;
            end
            default: begin
                cal_state_nxt = RMB_CAL_IDLE;
            end
        endcase
        if (!rst_pin_s) begin
            cal_state_nxt = RMB_CAL_IDLE; // RL12
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cal_state_r <= RMB_CAL_IDLE;
        end else begin
            cal_state_r <= cal_state_nxt;
        end
    end

    // Cycle count of the running routine
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cal_cnt_r <= 32'h0000_0000;
        end else if (cal_state_r != RMB_CAL_RUN) begin
            cal_cnt_r <= 32'h0000_0000;
        end else begin
            cal_cnt_r <= cal_cnt_r + 32'h0000_0001;
        end
    end

    // Start pulse and busy level from registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CAL_START <= 1'b0;
            CAL_BUSY  <= 1'b0;
        end else begin
            CAL_START <= cal_state_r == RMB_CAL_IDLE
                         && cal_state_nxt == RMB_CAL_RUN; // RL8
            CAL_BUSY  <= cal_state_nxt == RMB_CAL_RUN;
        end
    end

    // Effective bias: low-power bit overrides the converter field
    always_comb begin
        conv_lp_val = reg_val(4, delta_r[4], strap_duplex_r, strap_config_r);
        bias_eff    = reg_val(5, delta_r[5], strap_duplex_r, strap_config_r);
        if (conv_lp_val[`RMB_CONV_LP_BIT]) begin
            bias_eff[`RMB_ADC_HI:`RMB_ADC_LO] = `RMB_ADC_LP_CODE; // RL3
        end
    end

    // Configuration outputs registered; the soft reset pulse goes to the
    // datapath resets but not to the transmit filter, which keeps its data
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            FULL_DUPLEX              <= 1'b0;
            PD_LOW_SET               <= 8'h00;
            PD_HIGH_SET              <= 8'h00;
            HDX_PWR_CFG              <= 8'h00;
            CONTINUOUS_GAIN_AMP_BIAS <= 3'h0;
            SWITCHED_GAIN_AMP_BIAS   <= 2'h0;
            CONVERTER_BIAS           <= 3'h0;
            SOFT_RST_PULSE           <= 1'b0;
        end else begin
            FULL_DUPLEX <= strap_duplex_r; // RL4
            PD_LOW_SET  <= reg_val(1, delta_r[1], strap_duplex_r,
                                   strap_config_r);
            PD_HIGH_SET <= reg_val(2, delta_r[2], strap_duplex_r,
                                   strap_config_r);
            HDX_PWR_CFG <= reg_val(3, delta_r[3], strap_duplex_r,
                                   strap_config_r);
            CONTINUOUS_GAIN_AMP_BIAS <=
                bias_eff[`RMB_CGA_HI:`RMB_CGA_LO]; // RL1
            SWITCHED_GAIN_AMP_BIAS   <=
                bias_eff[`RMB_SGA_HI:`RMB_SGA_LO]; // RL1
            CONVERTER_BIAS           <=
                bias_eff[`RMB_ADC_HI:`RMB_ADC_LO]; // RL1
            SOFT_RST_PULSE <= soft_rst_r; // RL9
        end
    end

endmodule

/* File: verilog/rmb_defs.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef RMB_DEFS_SVH
`define RMB_DEFS_SVH

// Serial register offsets
`define RMB_ADDR_CTRL        7'h00
`define RMB_ADDR_PD_LOW      7'h01
`define RMB_ADDR_PD_HIGH     7'h02
`define RMB_ADDR_HDX_PWR     7'h03
`define RMB_ADDR_CONV_LP     7'h07
`define RMB_ADDR_BIAS        7'h13

// Field positions
`define RMB_CTRL_SOFT_RST    5
`define RMB_CTRL_EARLY       0
`define RMB_CONV_LP_BIT      4
`define RMB_CGA_HI           7
`define RMB_CGA_LO           5
`define RMB_SGA_HI           4
`define RMB_SGA_LO           3
`define RMB_ADC_HI           2
`define RMB_ADC_LO           0

// Reset values and the converter low-power code
`define RMB_RST_BIAS         8'h00
`define RMB_RST_CTRL         8'h00
`define RMB_RST_CONV_LP      8'h00
`define RMB_RST_PD_LOW       8'h00
`define RMB_RST_PD_HIGH      8'h7F
`define RMB_RST_PD_HIGH_ALL  8'hFF
`define RMB_RST_HDX_PWR      8'hFB
`define RMB_ADC_LP_CODE      3'h3

// Serial frame layout: read flag, 7-bit address, 8-bit data
`define RMB_FRAME_BITS       5'h10
`define RMB_HDR_BITS         5'h08

// Timing
`define RMB_CLK_MHZ          200
`define RMB_T_RST_MIN_NS     50
`define RMB_RST_MIN_CYC      ((`RMB_T_RST_MIN_NS * `RMB_CLK_MHZ + 999) / 1000)
`define RMB_T_PWR_ON_MS      10
`define RMB_PWR_ON_CYC       (`RMB_T_PWR_ON_MS * `RMB_CLK_MHZ * 1000)
`define RMB_CAL_CYC          1024

`endif

/* File: verilog/rmb_pkg.sv */
// Types shared by the reset, mode and bias configuration block
package rmb_pkg;

    typedef logic [7:0] rmb_byte_t;
    typedef logic [6:0] rmb_addr_t;

    // Calibration sequencer states
    typedef enum logic [2:0] {
        RMB_CAL_IDLE = 3'b001,
        RMB_CAL_RUN  = 3'b010,
        RMB_CAL_DONE = 3'b100
    } rmb_cal_e;

endpackage

/* File: verilog/rmb_sync2.sv */
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module rmb_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

/* File: dv/rmb_checker.sv */
// Port-level assertions for the reset, mode and bias block
`timescale 1ns/1ps
module rmb_checker #(
    parameter int unsigned PWR_ON_CYCLES = 200,
    parameter int unsigned CAL_CYCLES    = 16
) (
    input wire logic               CLK_SYS,
    input wire logic               RST_N,
    input wire logic               RESET_PIN_N,
    input wire logic               DUPLEX_STRAP,
    input wire logic               CONFIG_STRAP,
    input wire logic               SERIAL_PORT_SELECT_N,
    input wire logic               SERIAL_DATA_OE,
    input wire logic               FULL_DUPLEX,
    input wire rmb_pkg::rmb_byte_t PD_LOW_SET,
    input wire rmb_pkg::rmb_byte_t PD_HIGH_SET,
    input wire rmb_pkg::rmb_byte_t HDX_PWR_CFG,
    input wire logic [2:0]         CONTINUOUS_GAIN_AMP_BIAS,
    input wire logic [1:0]         SWITCHED_GAIN_AMP_BIAS,
    input wire logic [2:0]         CONVERTER_BIAS,
    input wire logic               SOFT_RST_PULSE,
    input wire logic               CAL_START,
    input wire logic               CAL_BUSY
);
    import rmb_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [7:0]  since_rel_r;
    int unsigned busy_cnt_r;
    logic [7:0]  bias;
    assign bias = {CONTINUOUS_GAIN_AMP_BIAS, SWITCHED_GAIN_AMP_BIAS,
                   CONVERTER_BIAS};

    // Cycles since the reset pin was last seen low; saturates, never wraps
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) since_rel_r <= 8'hFF;
        else if (!RESET_PIN_N) since_rel_r <= 8'h00;
        else if (since_rel_r != 8'hFF) since_rel_r <= since_rel_r + 8'h01;
    end

    // Length of the current calibration busy run
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) busy_cnt_r <= 0;
        else if (CAL_BUSY) busy_cnt_r <= busy_cnt_r + 1;
        else busy_cnt_r <= 0;
    end

    // Pin low long enough for the strap synchronisers to settle
    sequence pin_held_s;
        (!RESET_PIN_N && $stable(DUPLEX_STRAP) && $stable(CONFIG_STRAP))[*6];
    endsequence
    sequence port_idle_s;
        (SERIAL_PORT_SELECT_N && RESET_PIN_N)[*8];
    endsequence

    bias_clear_a: assert property (
        (!RESET_PIN_N)[*2] |-> bias == 8'h00)
        else $error("bias fields not cleared by reset pin");
    duplex_mode_a: assert property (
        pin_held_s |-> FULL_DUPLEX == DUPLEX_STRAP)
        else $error("duplex mode differs from strap");
    strap_default_a: assert property (
        pin_held_s |-> PD_LOW_SET == 8'h00 && HDX_PWR_CFG == 8'hFB &&
        PD_HIGH_SET == ((DUPLEX_STRAP && CONFIG_STRAP) ? 8'hFF : 8'h7F))
        else $error("strap defaults wrong");
    cal_follows_a: assert property (
        $rose(RESET_PIN_N) |-> ##[1:8] CAL_START)
        else $error("no calibration start after pin release");
    cal_gate_a: assert property (
        CAL_START |-> since_rel_r >= 8'h01 && since_rel_r <= 8'h08)
        else $error("calibration start not tied to pin release");
    cal_length_a: assert property (
        $fell(CAL_BUSY) && since_rel_r > 8'h08 |->
        busy_cnt_r == CAL_CYCLES)
        else $error("calibration busy length wrong");
    soft_defaults_a: assert property (
        SOFT_RST_PULSE |-> ##[0:3] (bias == 8'h00 && PD_LOW_SET == 8'h00))
        else $error("soft reset did not restore defaults");
    soft_once_a: assert property (
        $rose(SOFT_RST_PULSE) |=> (!SOFT_RST_PULSE)[*8])
        else $error("soft reset repeated");
    port_off_a: assert property (
        SERIAL_PORT_SELECT_N[*4] |-> !SERIAL_DATA_OE)
        else $error("data driven while port deselected");
    regs_hold_a: assert property (
        port_idle_s |-> $stable(bias) && $stable(PD_LOW_SET) &&
        $stable(PD_HIGH_SET) && $stable(HDX_PWR_CFG))
        else $error("registers changed with port idle");
endmodule

bind rmb_reset_mode_bias rmb_checker #(
    .PWR_ON_CYCLES(PWR_ON_CYCLES),
    .CAL_CYCLES(CAL_CYCLES)
) rmb_checker_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N),
    .DUPLEX_STRAP(DUPLEX_STRAP), .CONFIG_STRAP(CONFIG_STRAP),
    .SERIAL_PORT_SELECT_N(SERIAL_PORT_SELECT_N),
    .SERIAL_DATA_OE(SERIAL_DATA_OE), .FULL_DUPLEX(FULL_DUPLEX),
    .PD_LOW_SET(PD_LOW_SET), .PD_HIGH_SET(PD_HIGH_SET),
    .HDX_PWR_CFG(HDX_PWR_CFG),
    .CONTINUOUS_GAIN_AMP_BIAS(CONTINUOUS_GAIN_AMP_BIAS),
    .SWITCHED_GAIN_AMP_BIAS(SWITCHED_GAIN_AMP_BIAS),
    .CONVERTER_BIAS(CONVERTER_BIAS), .SOFT_RST_PULSE(SOFT_RST_PULSE),
    .CAL_START(CAL_START), .CAL_BUSY(CAL_BUSY)
);

/* File: dv/rmb_host_model.sv */
// Host model: reset pin, strap pins and serial port master
`timescale 1ns/1ps
module rmb_host_model #(
    parameter int unsigned PWR_ON_CYCLES = 200
) (
    input  wire logic CLK_SYS,
    input  wire logic SERIAL_DATA_O,
    input  wire logic SERIAL_DATA_OE,
    output logic      RESET_PIN_N,
    output logic      DUPLEX_STRAP,
    output logic      CONFIG_STRAP,
    output logic      SERIAL_PORT_SELECT_N,
    output logic      SERIAL_CLK,
    output logic      SERIAL_DATA_I
);
    import rmb_pkg::*;
    localparam int HALF = 6; // Above the 4 clocks the sampler needs

    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask

    // Pin held low from power-up past the power-on time
    initial begin
        RESET_PIN_N = 1'b0;
        DUPLEX_STRAP = 1'b0;
        CONFIG_STRAP = 1'b0;
        SERIAL_PORT_SELECT_N = 1'b1;
        SERIAL_CLK = 1'b0;
        SERIAL_DATA_I = 1'b0;
        step(PWR_ON_CYCLES + 20);
        RESET_PIN_N = 1'b1;
    end

    // Pin level with straps; each level held 12 clocks, above 50 ns
    task automatic set_pin(input logic lvl, input logic dup, input logic cfg);
        RESET_PIN_N = lvl;
        DUPLEX_STRAP = dup;
        CONFIG_STRAP = cfg;
        step(12);
    endtask

    // One 16-bit frame; hold_off keeps select high to test refusal
    task automatic frame(input logic hold_off, input logic rd,
                         input rmb_addr_t a, input rmb_byte_t wd,
                         output rmb_byte_t rdat);
        logic [15:0] w;
        w = {rd, a, wd};
        rdat = 8'h00;
        SERIAL_PORT_SELECT_N = hold_off;
        step(HALF);
        for (int i = 15; i >= 0; i--) begin
            // Released line toggles so a stale level cannot pass as data
            SERIAL_DATA_I = (rd && i < 8) ? ~SERIAL_DATA_I : w[i];
            step(HALF);
            if (rd && i < 8) rdat[i] = SERIAL_DATA_OE ? SERIAL_DATA_O : 1'bx;
            SERIAL_CLK = 1'b1;
            step(HALF);
            SERIAL_CLK = 1'b0;
        end
        step(HALF);
        SERIAL_PORT_SELECT_N = 1'b1;
        SERIAL_DATA_I = ~SERIAL_DATA_I;
        step(HALF);
    endtask
endmodule

/* File: dv/rmb_reset_mode_bias_tb.sv */
// Self-checking bench for the reset, mode and bias block
`timescale 1ns/1ps
module rmb_reset_mode_bias_tb;
    import rmb_pkg::*;
    typedef struct {
        rmb_addr_t a;
        rmb_byte_t wd;
        rmb_byte_t rd;
        rmb_byte_t pv;
    } rmb_row_s;
    logic       CLK_SYS, RST_N, RESET_PIN_N, DUPLEX_STRAP, CONFIG_STRAP;
    logic       SEL_N, SCLK, SDI, SDO, SDO_OE, FULL_DUPLEX;
    logic       SOFT_RST_PULSE, CAL_START, CAL_BUSY;
    rmb_byte_t  pd_low, pd_high, hdx, r;
    logic [2:0] cga, conv;
    logic [1:0] sga;
    int         fails, comparisons, cal_seen, n;
    rmb_row_s   rows [7] = '{'{7'h13, 8'hA5, 8'hA5, 8'hA5},
        '{7'h13, 8'h5A, 8'h5A, 8'h5A}, '{7'h01, 8'h60, 8'h60, 8'h60},
        '{7'h02, 8'h05, 8'h05, 8'h05}, '{7'h03, 8'h12, 8'h12, 8'h12},
        '{7'h07, 8'h10, 8'h10, 8'h03}, '{7'h05, 8'h77, 8'h00, 8'h00}};

    rmb_reset_mode_bias #(.PWR_ON_CYCLES(200), .CAL_CYCLES(16))
    rmb_reset_mode_bias_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .RESET_PIN_N(RESET_PIN_N), .DUPLEX_STRAP(DUPLEX_STRAP),
        .CONFIG_STRAP(CONFIG_STRAP), .SERIAL_PORT_SELECT_N(SEL_N),
        .SERIAL_CLK(SCLK), .SERIAL_DATA_I(SDI), .SERIAL_DATA_O(SDO),
        .SERIAL_DATA_OE(SDO_OE), .FULL_DUPLEX(FULL_DUPLEX),
        .PD_LOW_SET(pd_low), .PD_HIGH_SET(pd_high), .HDX_PWR_CFG(hdx),
        .CONTINUOUS_GAIN_AMP_BIAS(cga), .SWITCHED_GAIN_AMP_BIAS(sga),
        .CONVERTER_BIAS(conv), .SOFT_RST_PULSE(SOFT_RST_PULSE),
        .CAL_START(CAL_START), .CAL_BUSY(CAL_BUSY));
    rmb_host_model #(.PWR_ON_CYCLES(200)) rmb_host_model_i (
        .CLK_SYS(CLK_SYS), .SERIAL_DATA_O(SDO), .SERIAL_DATA_OE(SDO_OE),
        .RESET_PIN_N(RESET_PIN_N), .DUPLEX_STRAP(DUPLEX_STRAP),
        .CONFIG_STRAP(CONFIG_STRAP), .SERIAL_PORT_SELECT_N(SEL_N),
        .SERIAL_CLK(SCLK), .SERIAL_DATA_I(SDI));

    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // Calibration starts counted so absence can be checked too
    always @(posedge CLK_SYS) begin
        if (CAL_START === 1'b1) cal_seen++;
    end

    task automatic chk(input rmb_byte_t got, input rmb_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input rmb_addr_t a, input rmb_byte_t d);
        rmb_byte_t x;
        rmb_host_model_i.frame(1'b0, 1'b0, a, d, x);
    endtask

    task automatic rd(input rmb_addr_t a, output rmb_byte_t d);
        rmb_host_model_i.frame(1'b0, 1'b1, a, 8'h00, d);
    endtask

    function automatic rmb_byte_t port_val(input rmb_addr_t a);
        case (a)
            7'h01: return pd_low;
            7'h02: return pd_high;
            7'h03: return hdx;
            7'h07: return {5'h00, conv};
            7'h13: return {cga, sga, conv};
            default: return 8'h00;
        endcase
    endfunction

    task automatic finish_test;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is near 5600 clocks; this allows about seven times that
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    initial begin
        fails = 0;
        comparisons = 0;
        cal_seen = 0;
        RST_N = 1'b0;
        repeat (4) @(posedge CLK_SYS);
        #1 RST_N = 1'b1;
        wait (RESET_PIN_N === 1'b1);
        repeat (20) @(posedge CLK_SYS);
        #1;
        chk(cal_seen[7:0], 8'h01);
        chk(port_val(7'h13), 8'h00);
        $display("power-up test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, r);
            chk(r, rows[i].rd);
            chk(port_val(rows[i].a), rows[i].pv);
        end
        $display("register table test done");
        for (int m = 0; m < 4; m++) begin
            wr(7'h13, 8'hFF);
            n = cal_seen;
            rmb_host_model_i.set_pin(1'b0, m[1], m[0]);
            chk(port_val(7'h13), 8'h00);
            chk(cal_seen[7:0], n[7:0]);
            chk({7'h00, FULL_DUPLEX}, {7'h00, m[1]});
            chk(pd_high, (m == 3) ? 8'hFF : 8'h7F);
            chk(hdx, 8'hFB);
            rmb_host_model_i.set_pin(1'b1, m[1], m[0]);
            chk(cal_seen[7:0], n[7:0] + 8'h01);
        end
        $display("strap and pin reset test done");
        wr(7'h13, 8'h81);
        wr(7'h02, 8'h05);
        n = cal_seen;
        wr(7'h00, 8'h20);
        rd(7'h00, r);
        chk(r, 8'h00);
        rd(7'h13, r);
        chk(r, 8'h00);
        chk(pd_high, 8'hFF);
        chk(cal_seen[7:0], n[7:0]);
        $display("soft reset test done");
        rmb_host_model_i.frame(1'b1, 1'b0, 7'h13, 8'h3C, r);
        rd(7'h13, r);
        chk(r, 8'h00);
        $display("deselected port test done");
        finish_test();
    end
endmodule
